//--- design/rrse_exec.sv
// Executor for return, literal return, rotates, literal subtract and sleep
`timescale 1ns/1ps
`default_nettype none
module rrse_exec
  import rrse_pkg::*;
#(
  parameter int PC_W = 15,
  parameter int STACK_DEPTH = 16,
  parameter int SP_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake-up pin, asynchronous
  input wire logic wakePin,
  // Oscillator stop request
  output logic sleepMode
);
  if (STACK_DEPTH != (1 << SP_W)) $error("STACK_DEPTH must be 2**SP_W");
  if (PC_W > 31) $error("PC_W too wide");
  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[i*8 +: 8] = newV[i*8 +: 8];
    end
    return res;
  endfunction
  // Architectural state
  logic [7:0] accReg; // Accumulator
  logic carryReg, halfReg, zeroReg; // Arithmetic flags
  logic powerDownReg, timeoutReg; // Sleep status flags, active low sense
  logic asleepReg; // Core halted
  logic [PC_W-1:0] pcReg; // Program counter
  logic [PC_W-1:0] stackMem [STACK_DEPTH]; // Return stack
  logic [SP_W-1:0] spReg; // Next free stack slot
  logic [6:0] faddrReg; // Bus pointer into file registers
  logic [7:0] wdogCntReg, wdogPreReg; // Watchdog counter and prescaler
  logic [11:0] instrReg; // Latched instruction word
  rrse_state_e stateReg;
  // Bus handshake
  logic pendReg; // Request seen, answer next edge
  logic busReq, busDo, busWr;
  logic [31:0] wdat;
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busDo = busReq & pendReg; // Edge at which access takes effect
  assign busWr = busDo & wb_we_i;
  assign wdat = mergeBytes(32'h0000_0000, wb_dat_i, wb_sel_i);
  // Instruction accepted only when idle and awake; refused silently otherwise
  logic issue;
  assign issue = busWr && (wb_adr_i == ADDR_INSTR) && (stateReg == EX_IDLE) && !asleepReg;
  // Decoded latched instruction
  rrse_op_e op;
  logic [7:0] lit;
  logic dest;
  assign op = rrse_op_e'(instrReg[INS_OP_LSB +: 3]);
  assign lit = instrReg[INS_LIT_LSB +: 8];
  assign dest = instrReg[INS_DEST_BIT];
  // File register memory
  logic ramWe;
  logic [6:0] ramWa, ramRa;
  logic [7:0] ramWd, ramRd;
  rrse_file_ram #(.DATA_W(8), .DEPTH(128), .ADDR_W(INS_FADDR_W)) uRam (
    .clk(clk),
    .wrEn(ramWe),
    .wrAddr(ramWa),
    .wrData(ramWd),
    .rdAddr(ramRa),
    .rdData(ramRd)
  );
  // Read address: operand of the instruction being written, else bus pointer
  always_comb begin
    if (busReq && wb_we_i && (wb_adr_i == ADDR_INSTR)) begin
      ramRa = wb_dat_i[INS_LIT_LSB +: INS_FADDR_W];
    end else begin
      ramRa = faddrReg;
    end
  end
  // Rotate and subtract datapath
  logic [7:0] rotRes;
  logic rotCarry;
  logic [8:0] subWide;
  always_comb begin
    if (op == OP_ROTL) begin
      rotRes = {ramRd[6:0], carryReg};
      rotCarry = ramRd[7];
    end else begin
      rotRes = {carryReg, ramRd[7:1]};
      rotCarry = ramRd[0];
    end
    subWide = {1'b0, lit} - {1'b0, accReg};
  end
  logic isRot, run1;
  assign run1 = (stateReg == EX_RUN1);
  assign isRot = (op == OP_ROTL) || (op == OP_ROTR);
  // Write port: rotate write-back has priority over the bus
  always_comb begin
    if (run1 && isRot && dest) begin
      ramWe = 1'b1;
      ramWa = instrReg[INS_LIT_LSB +: INS_FADDR_W];
      ramWd = rotRes;
    end else begin
      ramWe = busWr && (wb_adr_i == ADDR_FDATA);
      ramWa = faddrReg;
      ramWd = wdat[7:0];
    end
  end
  // Sequencer: returns take two cycles, the rest one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateReg <= EX_IDLE;
      instrReg <= '0;
    end else begin
      case (stateReg)
        EX_IDLE: begin
          if (issue) begin
            instrReg <= wdat[11:0];
            stateReg <= EX_RUN1;
          end
        end
        EX_RUN1: begin
          if (op == OP_RETURN || op == OP_RETLIT) stateReg <= EX_RUN2;
          else stateReg <= EX_IDLE;
        end
        EX_RUN2: stateReg <= EX_IDLE;
        default: stateReg <= EX_IDLE;
      endcase
    end
  end
  // Accumulator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accReg <= ACC_RESET;
    end else if (run1 && op == OP_RETLIT) begin
      accReg <= lit;
    end else if (run1 && isRot && !dest) begin
      accReg <= rotRes;
    end else if (run1 && op == OP_LITSUB) begin
      accReg <= subWide[7:0];
    end else if (busWr && wb_adr_i == ADDR_ACC && wb_sel_i[0]) begin
      accReg <= wb_dat_i[7:0];
    end
  end
  // Arithmetic flags; returns leave them alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      carryReg <= 1'b0;
      halfReg <= 1'b0;
      zeroReg <= 1'b0;
    end else if (run1 && isRot) begin
      carryReg <= rotCarry;
    end else if (run1 && op == OP_LITSUB) begin
      carryReg <= ~subWide[8];
      halfReg <= (accReg[3:0] <= lit[3:0]);
      zeroReg <= (subWide[7:0] == 8'h00);
    end else if (busWr && wb_adr_i == ADDR_STATUS && wb_sel_i[0]) begin
      carryReg <= wb_dat_i[ST_CARRY];
      halfReg <= wb_dat_i[ST_HALF];
      zeroReg <= wb_dat_i[ST_ZERO];
    end
  end
  // Sleep entry and wake-up; wake pin passes two flops first
  logic wakeMeta, wakeSync, wakeSeen;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
      wakeSeen <= 1'b0;
    end else begin
      wakeMeta <= wakePin;
      wakeSync <= wakeMeta;
      wakeSeen <= wakeSync;
    end
  end
  // Sleep status flags and halt; only reset brings power-down back to one, sleep also sets time-out to one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerDownReg <= POWER_DOWN_RESET;
      timeoutReg <= TIMEOUT_RESET;
      asleepReg <= 1'b0;
      sleepMode <= 1'b0;
    end else if (run1 && op == OP_SLEEP) begin
      powerDownReg <= 1'b0;
      timeoutReg <= 1'b1;
      asleepReg <= 1'b1;
      sleepMode <= 1'b1;
    end else if (wakeSync && !wakeSeen) begin
      asleepReg <= 1'b0; // Rising wake edge restarts the core
      sleepMode <= 1'b0;
    end
  end
  // Watchdog counter and prescaler, free running; sleep clears both
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdogPreReg <= WDOG_CLEAR;
      wdogCntReg <= WDOG_CLEAR;
    end else if (run1 && op == OP_SLEEP) begin
      wdogPreReg <= WDOG_CLEAR;
      wdogCntReg <= WDOG_CLEAR;
    end else begin
      wdogPreReg <= wdogPreReg + 8'h01;
      if (wdogPreReg == 8'hFF) wdogCntReg <= wdogCntReg + 8'h01;
    end
  end
  // Program counter and return stack; pop wraps when empty
  logic [SP_W-1:0] spTop;
  assign spTop = spReg - {{(SP_W-1){1'b0}}, 1'b1};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcReg <= '0;
      spReg <= '0;
    end else if (run1 && (op == OP_RETURN || op == OP_RETLIT)) begin
      pcReg <= stackMem[spTop];
      spReg <= spTop;
    end else if (busWr && wb_adr_i == ADDR_STACK) begin
      spReg <= spReg + {{(SP_W-1){1'b0}}, 1'b1};
    end else if (busWr && wb_adr_i == ADDR_PC) begin
      pcReg <= wdat[PC_W-1:0];
    end
  end
  // Stack storage, written only by bus pushes
  always_ff @(posedge clk) begin
    if (busWr && wb_adr_i == ADDR_STACK) begin
      stackMem[spReg] <= wdat[PC_W-1:0];
    end
  end
  // File pointer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      faddrReg <= '0;
    end else if (busWr && wb_adr_i == ADDR_FADDR && wb_sel_i[0]) begin
      faddrReg <= wb_dat_i[6:0];
    end
  end
  // Read mux; unmapped addresses read zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (wb_adr_i == ADDR_INSTR) begin
      rdMux[11:0] = instrReg;
    end else if (wb_adr_i == ADDR_ACC) begin
      rdMux[7:0] = accReg;
    end else if (wb_adr_i == ADDR_STATUS) begin
      rdMux[ST_CARRY] = carryReg;
      rdMux[ST_HALF] = halfReg;
      rdMux[ST_ZERO] = zeroReg;
      rdMux[ST_PDOWN] = powerDownReg;
      rdMux[ST_TMOUT] = timeoutReg;
      rdMux[ST_BUSY] = (stateReg != EX_IDLE);
      rdMux[ST_ASLEEP] = asleepReg;
    end else if (wb_adr_i == ADDR_PC) begin
      rdMux[PC_W-1:0] = pcReg;
    end else if (wb_adr_i == ADDR_STACK) begin
      rdMux[PC_W-1:0] = stackMem[spTop];
      rdMux[16 +: SP_W] = spReg;
    end else if (wb_adr_i == ADDR_FADDR) begin
      rdMux[6:0] = faddrReg;
    end else if (wb_adr_i == ADDR_FDATA) begin
      rdMux[7:0] = ramRd;
    end else if (wb_adr_i == ADDR_WDOG) begin
      rdMux[15:0] = {wdogPreReg, wdogCntReg};
    end
  end
  // Answer two edges after the request; the extra cycle lets RAM data settle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendReg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      pendReg <= busReq & ~pendReg;
      wb_ack_o <= busDo;
      if (busDo && !wb_we_i) wb_dat_o <= rdMux;
    end
  end
endmodule // rrse_exec
`default_nettype wire

//--- design/rrse_file_ram.sv
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rrse_file_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 128,
  parameter int ADDR_W = 7
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  // Storage, no reset so it maps onto RAM
  logic [DATA_W-1:0] mem [DEPTH];

  // Depth must fit the address width
  if (DEPTH > (1 << ADDR_W)) $error("DEPTH exceeds address range");

  // Write and registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // rrse_file_ram
`default_nettype wire

//--- design/rrse_pkg.sv
// Constants, opcodes and register map of the return/rotate/subtract/sleep executor
package rrse_pkg;
  // Bus register byte addresses
  localparam logic [7:0] ADDR_INSTR = 8'h00; // Issue an instruction
  localparam logic [7:0] ADDR_ACC = 8'h04; // Accumulator
  localparam logic [7:0] ADDR_STATUS = 8'h08; // Flags and state
  localparam logic [7:0] ADDR_PC = 8'h0C; // Program counter
  localparam logic [7:0] ADDR_STACK = 8'h10; // Write pushes, read shows top
  localparam logic [7:0] ADDR_FADDR = 8'h14; // File register pointer
  localparam logic [7:0] ADDR_FDATA = 8'h18; // File register data
  localparam logic [7:0] ADDR_WDOG = 8'h1C; // Watchdog counter and prescaler
  // Instruction word fields
  localparam int INS_LIT_LSB = 0; // Literal or file address, 8 bits
  localparam int INS_FADDR_W = 7; // File address width
  localparam int INS_DEST_BIT = 8; // Destination select
  localparam int INS_OP_LSB = 9; // Opcode, 3 bits
  // Status register bits
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PDOWN = 3; // Power-down flag, low after sleep
  localparam int ST_TMOUT = 4; // Time-out flag, high after sleep
  localparam int ST_BUSY = 5;
  localparam int ST_ASLEEP = 6;
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic POWER_DOWN_RESET = 1'b1;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  // Opcodes
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_RETURN = 3'h1,
    OP_RETLIT = 3'h2,
    OP_ROTL = 3'h3,
    OP_ROTR = 3'h4,
    OP_LITSUB = 3'h5,
    OP_SLEEP = 3'h6
  } rrse_op_e;
  // Executor states, one-hot
  typedef enum logic [2:0] {
    EX_IDLE = 3'b001,
    EX_RUN1 = 3'b010,
    EX_RUN2 = 3'b100
  } rrse_state_e;
endpackage

//--- verification/rrse_exec_properties.sv
// Port-level checks of the executor
`timescale 1ns/1ps
`default_nettype none
module rrse_exec_properties
  import rrse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sleep
  input wire logic wakePin,
  input wire logic sleepMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Fresh request, not one still held
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_cyc_i);
  endsequence
  // Pending cycle, then the answer
  sequence s_ans;
    !wb_ack_o ##1 wb_ack_o;
  endsequence
  property p_ackLat; s_req |=> s_ans; endproperty
  property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ackReq; wb_ack_o |-> wb_cyc_i && wb_stb_i; endproperty
  // Read data moves only with a read answer
  property p_datHold; $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i; endproperty
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0; endproperty
  // Sleep starts only right after an acknowledged instruction write
  property p_sleepIn;
    $rose(sleepMode) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == ADDR_INSTR);
  endproperty
  // Flags read while asleep: power-down low, time-out high
  property p_sleepFlags;
    wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS && $past(sleepMode, 4)
      |-> wb_dat_o[4:3] == 2'b10;
  endproperty
  // Only the wake pin ends sleep
  property p_wake;
    $fell(sleepMode) |-> $past(wakePin, 2) || $past(wakePin, 3) || $past(wakePin, 4);
  endproperty
  a_ackLat: assert property (p_ackLat) else $error("ack latency wrong");
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  a_ackReq: assert property (p_ackReq) else $error("ack without request");
  a_datHold: assert property (p_datHold) else $error("read data moved unasked");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_sleepIn: assert property (p_sleepIn) else $error("sleep entry wrong");
  a_sleepFlags: assert property (p_sleepFlags) else $error("sleep flags wrong");
  a_wake: assert property (p_wake) else $error("sleep left without wake");
endmodule // rrse_exec_properties
bind rrse_exec rrse_exec_properties uChk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wakePin(wakePin), .sleepMode(sleepMode));
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rrse_pkg::*;
;
  // Bus and pin drives
  logic clk, rst, cyc, stb, we, wake, ack, slp;
  logic [7:0] adr, a, k, r;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] tab [5];
  int errTotal, numChecks, n;
  rrse_exec uut (.clk(clk), .sys_rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wakePin(wake), .sleepMode(slp));
  // 25 ns clock
  always #12.5 clk = ~clk;
  // Verdict and end of run
  task automatic completeRun;
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single cycle, held until ack, bounded wait
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int c;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (ack !== 1'b1 && c < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (c >= 20) begin
      errTotal++;
      $display("MISMATCH ack expected 1 seen timeout");
      completeRun();
    end
  endtask
  // Read and compare under a mask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    bus(1'b0, ad, 32'h0);
    chk(nm, e, q & m);
  endtask
  // Issue one instruction and let it finish
  task automatic ex(input logic [2:0] op, input logic d, input logic [7:0] lit);
    bus(1'b1, ADDR_INSTR, {20'h0, op, d, lit});
    repeat (3) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, wake} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    {errTotal, numChecks} = 0;
    // Subtract cases: accumulator, literal
    tab = '{16'h0505, 16'h0605, 16'h1F20, 16'h100F, 16'h00FF};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_ACC, 32'hFF, 32'h0, "acc");
    rchk(ADDR_STATUS, 32'h1F, 32'h18, "status");
    bus(1'b1, 8'h20, 32'h55);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test reset done");
    bus(1'b1, ADDR_STATUS, 32'h7);
    bus(1'b1, ADDR_STACK, 32'h1234);
    ex(OP_RETURN, 1'b0, 8'h00);
    rchk(ADDR_PC, 32'h7FFF, 32'h1234, "pc");
    rchk(ADDR_STATUS, 32'h7, 32'h7, "flags");
    bus(1'b1, ADDR_STACK, 32'h0456);
    ex(OP_RETLIT, 1'b0, 8'hA5);
    rchk(ADDR_ACC, 32'hFF, 32'hA5, "acc");
    rchk(ADDR_PC, 32'h7FFF, 32'h0456, "pc");
    rchk(ADDR_STATUS, 32'h7, 32'h7, "flags");
    $display("test returns done");
    bus(1'b1, ADDR_FADDR, 32'h7F);
    bus(1'b1, ADDR_FDATA, 32'hE6);
    bus(1'b1, ADDR_STATUS, 32'h6);
    ex(OP_ROTL, 1'b0, 8'h7F);
    rchk(ADDR_ACC, 32'hFF, 32'hCC, "acc");
    rchk(ADDR_STATUS, 32'h7, 32'h7, "flags");
    rchk(ADDR_FDATA, 32'hFF, 32'hE6, "file");
    ex(OP_ROTR, 1'b1, 8'h7F);
    rchk(ADDR_FDATA, 32'hFF, 32'hF3, "file");
    rchk(ADDR_STATUS, 32'h7, 32'h6, "flags");
    rchk(ADDR_ACC, 32'hFF, 32'hCC, "acc");
    $display("test rotates done");
    foreach (tab[i]) begin
      a = tab[i][15:8];
      k = tab[i][7:0];
      r = k - a;
      bus(1'b1, ADDR_ACC, {24'h0, a});
      ex(OP_LITSUB, 1'b0, k);
      rchk(ADDR_ACC, 32'hFF, {24'h0, r}, "diff");
      rchk(ADDR_STATUS, 32'h7, {29'h0, r == 8'h00, a[3:0] <= k[3:0], a <= k}, "flags");
    end
    $display("test subtract done");
    // Let the watchdog step at least once so that its clear is visible
    repeat (256) @(posedge clk);
    bus(1'b0, ADDR_WDOG, 32'h0);
    chk("watchdog running", 32'h1, {31'h0, q[7:0] != 8'h00});
    ex(OP_SLEEP, 1'b0, 8'h00);
    chk("asleep", 32'h1, {31'h0, slp});
    rchk(ADDR_STATUS, 32'h58, 32'h50, "sleep flags");
    rchk(ADDR_WDOG, 32'hFF, 32'h0, "watchdog");
    chk("prescaler", 32'h1, {31'h0, q[15:8] < 8'h20});
    // Execution halted: this literal return must be ignored
    ex(OP_RETLIT, 1'b0, 8'h3C);
    rchk(ADDR_ACC, 32'hFF, 32'hFF, "acc");
    wake <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (slp !== 1'b0 && n < 20);
    wake <= 1'b0;
    chk("awake", 32'h0, {31'h0, slp});
    $display("test sleep done");
    completeRun();
  end
endmodule // tb_top
`default_nettype wire
